// ---- core/tlb_pkg.sv ----
// Purpose: shared constants, entry layout and states of the translation lookup block
// Assumes: 4 KB base pages, 2 MB blocks, 48-bit virtual and 40-bit physical addresses
// Notes:   register offsets are byte addresses on the APB slave
package tlb_pkg;
    localparam int VA_W   = 48;
    localparam int PA_W   = 40;
    localparam int PG_W   = 12;
    localparam int VPN_W  = VA_W - PG_W;
    localparam int PPN_W  = PA_W - PG_W;
    localparam int BIG_W  = 9;
    localparam int APPLICATION_SPACE_TAG_W = 16;
    localparam int GUEST_MACHINE_TAG_W = 8;
    localparam int ATTR_W = 8;
    localparam int PERM_W = 2;
    localparam int ADDR_W = 12;
    localparam int MICRO_N   = 10;
    localparam int WAYS      = 4;
    localparam int MAIN_SETS = 128;
    localparam int MAIN_IW   = 7;
    localparam int SC_SETS   = 16;
    localparam int SC_IW     = 4;
    // memory space codes
    localparam logic [1:0] SP_MON_WIDE = 2'h0;
    localparam logic [1:0] SP_HYP      = 2'h1;
    localparam logic [1:0] SP_SEC_LOW  = 2'h2;
    localparam logic [1:0] SP_NS_LOW   = 2'h3;
    localparam logic [1:0] LVL_HYP = 2'h2;
    localparam logic [1:0] LVL_MON = 2'h3;
    // registers
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_APPLICATION_SPACE_TAG   = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_GUEST_MACHINE_TAG   = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_MAINT  = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;
    localparam int CTRL_S1_BIT = 0;
    localparam int CTRL_S2_BIT = 1;
    localparam int CTRL_MW_BIT = 2;
    localparam int MAINT_GO_BIT = 0;
    localparam logic [2:0]        CTRL_RST = 3'h0;
    localparam logic [APPLICATION_SPACE_TAG_W-1:0] APPLICATION_SPACE_TAG_RST = 16'h0000;
    localparam logic [GUEST_MACHINE_TAG_W-1:0] GUEST_MACHINE_TAG_RST = 8'h00;
    localparam logic [ATTR_W-1:0] ATTR_BYPASS = 8'h00;
    localparam logic [PERM_W-1:0] PERM_FULL   = 2'h3;

    typedef struct packed {
        logic [VPN_W-1:0]  vpn;
        logic              big;
        logic [PPN_W-1:0]  ppn;
        logic [ATTR_W-1:0] attr;
        logic [PERM_W-1:0] perm;
        logic [APPLICATION_SPACE_TAG_W-1:0] application_space_tag;
        logic              glob;
        logic [GUEST_MACHINE_TAG_W-1:0] guest_machine_tag;
        logic [1:0]        space;
    } tlb_entry_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_MICRO, ST_MAIN, ST_S1, ST_S1_WAIT, ST_S2, ST_S2_WAIT, ST_INSTALL
    } state_e;
endpackage

// ---- core/two_stage_tlb_lookup.sv ----
// Purpose: per-CPU translation lookup: micro TLBs, main TLB, walk cache, intermediate cache
// Assumes: one request at a time; the table walker answers every walk request with a fill
// Notes:   APB slave answers with one wait state
`timescale 1ns/1ps
module two_stage_tlb_lookup
    import tlb_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // lookup request
    input  wire logic              req_valid,
    input  wire logic              req_fetch,
    input  wire logic [VA_W-1:0]   req_va,
    input  wire logic [1:0]        req_level,
    input  wire logic              req_secure,
    output logic                   req_ready,
    // lookup answer
    output logic                   resp_valid,
    output logic                   resp_fetch,
    output logic      [PA_W-1:0]   resp_pa,
    output logic      [ATTR_W-1:0] resp_attr,
    output logic      [PERM_W-1:0] resp_perm,
    // table walker
    output logic                   walk_req_valid,
    output logic                   walk_req_stage2,
    output logic      [VA_W-1:0]   walk_req_addr,
    output logic      [1:0]        walk_req_space,
    input  wire logic              walk_fill_valid,
    input  wire logic [PPN_W-1:0]  walk_fill_ppn,
    input  wire logic              walk_fill_big,
    input  wire logic [ATTR_W-1:0] walk_fill_attr,
    input  wire logic [PERM_W-1:0] walk_fill_perm,
    input  wire logic              walk_fill_global,
    // system mmu notice
    output logic                   smmu_inval
);
    function automatic logic hit_fn(tlb_entry_s e, logic [VPN_W-1:0] vpn, logic [1:0] sp,
                                    logic [APPLICATION_SPACE_TAG_W-1:0] application_space_tag, logic [GUEST_MACHINE_TAG_W-1:0] guest_machine_tag);
        logic va_ok;
        logic as_ok;
        logic vm_ok;
        va_ok = e.big ? (e.vpn[VPN_W-1:BIG_W] == vpn[VPN_W-1:BIG_W]) : (e.vpn == vpn);
        as_ok = e.glob || e.application_space_tag == application_space_tag || sp == SP_HYP || sp == SP_MON_WIDE;
        vm_ok = sp != SP_NS_LOW || e.guest_machine_tag == guest_machine_tag;
        return va_ok && e.space == sp && as_ok && vm_ok;
    endfunction

    function automatic logic [PA_W-1:0] pa_of(tlb_entry_s e, logic [VA_W-1:0] va);
        logic [PPN_W-1:0] p;
        p = e.big ? {e.ppn[PPN_W-1:BIG_W], va[PG_W+BIG_W-1:PG_W]} : e.ppn;
        return {p, va[PG_W-1:0]};
    endfunction

    state_e            state;
    logic [2:0]        ctrl;
    logic [APPLICATION_SPACE_TAG_W-1:0] application_space_tag_cur;
    logic [GUEST_MACHINE_TAG_W-1:0] guest_machine_tag_cur;
    logic              maint_pend;
    logic [VA_W-1:0]   q_va;
    logic              q_fetch;
    logic [1:0]        q_space;
    tlb_entry_s        cur;

    // storage: tags carry context so switches need no flush
    tlb_entry_s        micro_e [2][MICRO_N];
    logic [MICRO_N-1:0] micro_v [2];
    logic [3:0]        micro_rr [2];
    tlb_entry_s        main_e [MAIN_SETS][WAYS];
    logic [WAYS-1:0]   main_v [MAIN_SETS];
    logic [1:0]        main_rr [MAIN_SETS];
    tlb_entry_s        walk_e [SC_SETS][WAYS];
    logic [WAYS-1:0]   walk_v [SC_SETS];
    logic [1:0]        walk_rr [SC_SETS];
    tlb_entry_s        ipa_e [SC_SETS][WAYS];
    logic [WAYS-1:0]   ipa_v [SC_SETS];
    logic [1:0]        ipa_rr [SC_SETS];

    logic              apb_acc;
    logic              apb_wr;
    logic              accept;
    logic              do_maint;
    logic              side;
    logic [VPN_W-1:0]  q_vpn;
    logic [PA_W-1:0]   q_ipa;
    logic [PPN_W-1:0]  q_ipn;
    logic              s2_used;
    logic              m_hit, mm_hit, wc_hit, ic_hit;
    tlb_entry_s        m_ent, mm_ent, wc_ent, ic_ent, inst_e, fill_e, micro_wr;
    logic              wr_micro, wr_main, wr_walk, wr_ipa;
    logic [1:0]        next_space;

    assign apb_acc  = psel && penable && !pready;
    assign apb_wr   = psel && penable && pready && pwrite;
    assign accept   = state == ST_IDLE && req_valid && req_ready;
    assign do_maint = state == ST_IDLE && maint_pend && !accept;
    assign side     = !q_fetch;
    assign q_vpn    = q_va[VA_W-1:PG_W];
    assign q_ipa    = pa_of(cur, q_va);
    assign q_ipn    = q_ipa[PA_W-1:PG_W];
    assign s2_used  = ctrl[CTRL_S2_BIT] && q_space == SP_NS_LOW;

    // memory space of an incoming request
    always_comb begin
        if (req_level == LVL_MON && ctrl[CTRL_MW_BIT]) next_space = SP_MON_WIDE;
        else if (req_level == LVL_HYP) next_space = SP_HYP;
        else if (req_secure) next_space = SP_SEC_LOW;
        else next_space = SP_NS_LOW;
    end

    // parallel tag compares
    always_comb begin
        m_hit = 1'b0;
        m_ent = micro_e[side][0];
        mm_hit = 1'b0;
        mm_ent = main_e[q_vpn[MAIN_IW-1:0]][0];
        wc_hit = 1'b0;
        wc_ent = walk_e[q_vpn[SC_IW-1:0]][0];
        ic_hit = 1'b0;
        ic_ent = ipa_e[q_ipn[SC_IW-1:0]][0];
        for (int i = 0; i < MICRO_N; i++) begin
            if (micro_v[side][i] && hit_fn(micro_e[side][i], q_vpn, q_space, application_space_tag_cur, guest_machine_tag_cur)) begin
                m_hit = 1'b1;
                m_ent = micro_e[side][i];
            end
        end
        for (int w = 0; w < WAYS; w++) begin
            if (main_v[q_vpn[MAIN_IW-1:0]][w]
                && hit_fn(main_e[q_vpn[MAIN_IW-1:0]][w], q_vpn, q_space, application_space_tag_cur, guest_machine_tag_cur)) begin
                mm_hit = 1'b1;
                mm_ent = main_e[q_vpn[MAIN_IW-1:0]][w];
            end
            if (walk_v[q_vpn[SC_IW-1:0]][w]
                && hit_fn(walk_e[q_vpn[SC_IW-1:0]][w], q_vpn, q_space, application_space_tag_cur, guest_machine_tag_cur)) begin
                wc_hit = 1'b1;
                wc_ent = walk_e[q_vpn[SC_IW-1:0]][w];
            end
            if (ipa_v[q_ipn[SC_IW-1:0]][w] && ipa_e[q_ipn[SC_IW-1:0]][w].ppn == q_ipn
                && ipa_e[q_ipn[SC_IW-1:0]][w].guest_machine_tag == guest_machine_tag_cur) begin
                ic_hit = 1'b1;
                ic_ent = ipa_e[q_ipn[SC_IW-1:0]][w];
            end
        end
    end

    // entries built for installs and fills
    always_comb begin
        inst_e = cur;
        inst_e.vpn = q_vpn;
        inst_e.application_space_tag = application_space_tag_cur;
        inst_e.guest_machine_tag = guest_machine_tag_cur;
        inst_e.space = q_space;
        fill_e = inst_e;
        fill_e.ppn = walk_fill_ppn;
        fill_e.big = walk_fill_big;
        fill_e.attr = walk_fill_attr;
        fill_e.perm = walk_fill_perm;
        fill_e.glob = walk_fill_global;
        if (state == ST_S2_WAIT) begin
            fill_e.ppn = q_ipn;
            fill_e.vpn = {{(VPN_W-PPN_W){1'b0}}, walk_fill_ppn};
        end
        micro_wr = (state == ST_MAIN) ? mm_ent : inst_e;
        wr_micro = (state == ST_MAIN && mm_hit) || state == ST_INSTALL;
        wr_main = state == ST_INSTALL;
        wr_walk = state == ST_S1_WAIT && walk_fill_valid;
        wr_ipa = state == ST_S2_WAIT && walk_fill_valid;
    end

    // apb slave with one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_acc;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (apb_acc) begin
                unique case (paddr)
                    OFS_CTRL:   prdata <= {29'h0, ctrl};
                    OFS_APPLICATION_SPACE_TAG:   prdata <= {16'h0, application_space_tag_cur};
                    OFS_GUEST_MACHINE_TAG:   prdata <= {24'h0, guest_machine_tag_cur};
                    OFS_MAINT:  prdata <= {31'h0, maint_pend};
                    OFS_STATUS: prdata <= {27'h0, walk_req_stage2, walk_req_valid, state != ST_IDLE, 2'h0};
                    default:    pslverr <= 1'b1;
                endcase
            end
        end
    end

    // software controls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST;
            application_space_tag_cur <= APPLICATION_SPACE_TAG_RST;
            guest_machine_tag_cur <= GUEST_MACHINE_TAG_RST;
        end else if (apb_wr) begin
            if (paddr == OFS_CTRL) ctrl <= pwdata[2:0];
            if (paddr == OFS_APPLICATION_SPACE_TAG) application_space_tag_cur <= pwdata[APPLICATION_SPACE_TAG_W-1:0];
            if (paddr == OFS_GUEST_MACHINE_TAG) guest_machine_tag_cur <= pwdata[GUEST_MACHINE_TAG_W-1:0];
        end
    end

    // maintenance request: a new write wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            maint_pend <= 1'b0;
            smmu_inval <= 1'b0;
        end else begin
            if (apb_wr && paddr == OFS_MAINT && pwdata[MAINT_GO_BIT]) maint_pend <= 1'b1;
            else if (do_maint) maint_pend <= 1'b0;
            smmu_inval <= do_maint;
        end
    end

    // lookup sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            req_ready <= 1'b1;
            q_va <= '0;
            q_fetch <= 1'b0;
            q_space <= SP_NS_LOW;
            cur <= '0;
            resp_valid <= 1'b0;
            resp_fetch <= 1'b0;
            resp_pa <= '0;
            resp_attr <= '0;
            resp_perm <= '0;
            walk_req_valid <= 1'b0;
            walk_req_stage2 <= 1'b0;
            walk_req_addr <= '0;
            walk_req_space <= '0;
        end else begin
            resp_valid <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    req_ready <= !accept && (!maint_pend || do_maint);
                    if (accept) begin
                        q_va <= req_va;
                        q_fetch <= req_fetch;
                        q_space <= next_space;
                        state <= ST_MICRO;
                    end
                end
                ST_MICRO: begin
                    if (m_hit) begin
                        resp_valid <= 1'b1;
                        resp_fetch <= q_fetch;
                        resp_pa <= pa_of(m_ent, q_va);
                        resp_attr <= m_ent.attr;
                        resp_perm <= m_ent.perm;
                        req_ready <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_MAIN;
                    end
                end
                ST_MAIN: begin
                    if (mm_hit) begin
                        resp_valid <= 1'b1;
                        resp_fetch <= q_fetch;
                        resp_pa <= pa_of(mm_ent, q_va);
                        resp_attr <= mm_ent.attr;
                        resp_perm <= mm_ent.perm;
                        req_ready <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_S1;
                    end
                end
                ST_S1: begin
                    if (!ctrl[CTRL_S1_BIT]) begin
                        cur <= '0;
                        cur.ppn <= q_va[PA_W-1:PG_W];
                        cur.attr <= ATTR_BYPASS;
                        cur.perm <= PERM_FULL;
                        cur.glob <= 1'b1;
                        state <= ST_S2;
                    end else if (wc_hit) begin
                        cur <= wc_ent;
                        state <= ST_S2;
                    end else begin
                        walk_req_valid <= 1'b1;
                        walk_req_stage2 <= 1'b0;
                        walk_req_addr <= {q_vpn, {PG_W{1'b0}}};
                        walk_req_space <= q_space;
                        state <= ST_S1_WAIT;
                    end
                end
                ST_S1_WAIT: begin
                    if (walk_fill_valid) begin
                        walk_req_valid <= 1'b0;
                        cur <= fill_e;
                        state <= ST_S2;
                    end
                end
                ST_S2: begin
                    if (!s2_used) begin
                        state <= ST_INSTALL;
                    end else if (ic_hit) begin
                        cur.ppn <= ic_ent.vpn[PPN_W-1:0];
                        cur.big <= 1'b0;
                        state <= ST_INSTALL;
                    end else begin
                        walk_req_valid <= 1'b1;
                        walk_req_stage2 <= 1'b1;
                        walk_req_addr <= {{(VA_W-PA_W){1'b0}}, q_ipn, {PG_W{1'b0}}};
                        walk_req_space <= q_space;
                        state <= ST_S2_WAIT;
                    end
                end
                ST_S2_WAIT: begin
                    if (walk_fill_valid) begin
                        walk_req_valid <= 1'b0;
                        cur.ppn <= walk_fill_ppn;
                        cur.big <= 1'b0;
                        if (!ctrl[CTRL_S1_BIT]) begin
                            cur.attr <= walk_fill_attr;
                            cur.perm <= walk_fill_perm;
                        end
                        state <= ST_INSTALL;
                    end
                end
                ST_INSTALL: begin
                    resp_valid <= 1'b1;
                    resp_fetch <= q_fetch;
                    resp_pa <= pa_of(inst_e, q_va);
                    resp_attr <= inst_e.attr;
                    resp_perm <= inst_e.perm;
                    req_ready <= 1'b1;
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // valid bits and round-robin victims; maintenance clears all valid bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int s = 0; s < 2; s++) begin
                micro_v[s] <= '0;
                micro_rr[s] <= 4'h0;
            end
            for (int s = 0; s < MAIN_SETS; s++) begin
                main_v[s] <= '0;
                main_rr[s] <= 2'h0;
            end
            for (int s = 0; s < SC_SETS; s++) begin
                walk_v[s] <= '0;
                walk_rr[s] <= 2'h0;
                ipa_v[s] <= '0;
                ipa_rr[s] <= 2'h0;
            end
        end else if (do_maint) begin
            for (int s = 0; s < 2; s++) micro_v[s] <= '0;
            for (int s = 0; s < MAIN_SETS; s++) main_v[s] <= '0;
            for (int s = 0; s < SC_SETS; s++) begin
                walk_v[s] <= '0;
                ipa_v[s] <= '0;
            end
        end else begin
            if (wr_micro) begin
                micro_v[side][micro_rr[side]] <= 1'b1;
                micro_rr[side] <= (micro_rr[side] == 4'(MICRO_N - 1)) ? 4'h0 : micro_rr[side] + 4'h1;
            end
            if (wr_main) begin
                main_v[q_vpn[MAIN_IW-1:0]][main_rr[q_vpn[MAIN_IW-1:0]]] <= 1'b1;
                main_rr[q_vpn[MAIN_IW-1:0]] <= main_rr[q_vpn[MAIN_IW-1:0]] + 2'h1;
            end
            if (wr_walk) begin
                walk_v[q_vpn[SC_IW-1:0]][walk_rr[q_vpn[SC_IW-1:0]]] <= 1'b1;
                walk_rr[q_vpn[SC_IW-1:0]] <= walk_rr[q_vpn[SC_IW-1:0]] + 2'h1;
            end
            if (wr_ipa) begin
                ipa_v[q_ipn[SC_IW-1:0]][ipa_rr[q_ipn[SC_IW-1:0]]] <= 1'b1;
                ipa_rr[q_ipn[SC_IW-1:0]] <= ipa_rr[q_ipn[SC_IW-1:0]] + 2'h1;
            end
        end
    end

    // entry contents, no reset needed behind the valid bits
    always_ff @(posedge pclk) begin
        if (wr_micro) micro_e[side][micro_rr[side]] <= micro_wr;
        if (wr_main) main_e[q_vpn[MAIN_IW-1:0]][main_rr[q_vpn[MAIN_IW-1:0]]] <= inst_e;
        if (wr_walk) walk_e[q_vpn[SC_IW-1:0]][walk_rr[q_vpn[SC_IW-1:0]]] <= fill_e;
        if (wr_ipa) ipa_e[q_ipn[SC_IW-1:0]][ipa_rr[q_ipn[SC_IW-1:0]]] <= fill_e;
    end
endmodule // two_stage_tlb_lookup

// ---- verif/tlb_props.sv ----
// Purpose: port checks for the translation lookup block
// Assumes: one apb wait state; walker answers every walk
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module tlb_props
    import tlb_pkg::*;
(
    // apb side
    input wire logic              pclk, presetn, psel, penable, pwrite, pready,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    // lookup and walker side
    input wire logic              req_valid, req_ready, resp_valid, walk_req_valid, walk_fill_valid, smmu_inval,
    input wire logic [VA_W-1:0]   walk_req_addr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic take  = req_valid && req_ready;
    wire logic maint = psel && penable && pready && pwrite && paddr == OFS_MAINT && pwdata[MAINT_GO_BIT];
    a_apb_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_apb_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_take_stall: assert property (take |=> !req_ready && !resp_valid)
        else $error("request port not stalled after take");
    a_answer_bound: assert property (take |-> ##[2:60] resp_valid) else $error("lookup not answered");
    a_resp_reopen: assert property (resp_valid |-> req_ready ##1 !resp_valid) else $error("answer handshake wrong");
    a_walk_stall: assert property (walk_req_valid |-> !req_ready) else $error("port open during walk");
    a_walk_held: assert property (walk_req_valid && !walk_fill_valid |=> walk_req_valid && $stable(walk_req_addr))
        else $error("walk request dropped or changed");
    a_walk_aligned: assert property (walk_req_valid |-> walk_req_addr[PG_W-1:0] == '0)
        else $error("walk address not page aligned");
    a_inval_notice: assert property (maint |-> ##[1:60] smmu_inval) else $error("no invalidate notice");
    c_walk: cover property (walk_fill_valid);
    c_inval: cover property (smmu_inval);
    c_fast_hit: cover property (take ##2 resp_valid);
endmodule // tlb_props
bind two_stage_tlb_lookup tlb_props u_tlb_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .paddr, .pwdata,
    .req_valid, .req_ready, .resp_valid, .walk_req_valid, .walk_fill_valid, .smmu_inval, .walk_req_addr);

// ---- verif/tlb_walker_model.sv ----
// Purpose: table walker stand-in answering walk requests
// Assumes: stage one only; page is request page plus one
// Notes:   answer delay cycles through 0, 1 and 2 waits
`timescale 1ns/1ps
module tlb_walker_model
    import tlb_pkg::*;
(
    // walk request
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              walk_req_valid,
    input  wire logic [VA_W-1:0]   walk_req_addr,
    // fill answer
    output logic                   walk_fill_valid,
    output logic      [PPN_W-1:0]  walk_fill_ppn,
    output logic      [ATTR_W-1:0] walk_fill_attr,
    output logic      [PERM_W-1:0] walk_fill_perm,
    output int                     walks
);
    int wait_n;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            walk_fill_valid <= 1'b0;
            walk_fill_ppn   <= '0;
            walk_fill_attr  <= '0;
            walk_fill_perm  <= 2'h1;
            walks           <= 0;
            wait_n          <= 0;
        end else begin
            walk_fill_valid <= 1'b0;
            walk_fill_ppn   <= ~walk_fill_ppn;
            walk_fill_attr  <= ~walk_fill_attr;
            if (walk_req_valid && !walk_fill_valid) begin
                wait_n <= wait_n + 1;
                if (wait_n >= walks % 3) begin
                    walk_fill_valid <= 1'b1;
                    walk_fill_ppn   <= walk_req_addr[PG_W +: PPN_W] + 28'h1;
                    walk_fill_attr  <= 8'h5A;
                    walks           <= walks + 1;
                    wait_n          <= 0;
                end
            end
        end
    end
endmodule // tlb_walker_model

// ---- verif/two_stage_tlb_lookup_test.sv ----
// Purpose: self-checking bench for the translation lookup block
// Assumes: walker stand-in answers every walk; stage two left off
// Notes:   expected pages follow the walker page-plus-one rule with stage one on and equal the virtual page with it off; walk counts come from a reference map
`timescale 1ns/1ps
module two_stage_tlb_lookup_test;
    import tlb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid, req_fetch, req_secure, req_ready, s1;
    logic resp_valid, walk_req_valid, walk_fill_valid, walk_fill_big, walk_fill_global, smmu_inval, resp_fetch;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic [VA_W-1:0]   req_va, va, walk_req_addr;
    logic [1:0]        req_level;
    logic [PA_W-1:0]   resp_pa;
    logic [ATTR_W-1:0] resp_attr, walk_fill_attr;
    logic [PERM_W-1:0] resp_perm, walk_fill_perm;
    logic [PPN_W-1:0]  walk_fill_ppn;
    logic [15:0]       application_space_tag;
    int failures, cmp_count, walks, exp_walks, seed, lat, invals;
    bit seen [logic [63:0]];
    two_stage_tlb_lookup u_two_stage_tlb_lookup (.*, .walk_req_stage2(), .walk_req_space());
    tlb_walker_model u_tlb_walker_model (.*);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) if (smmu_inval) invals++;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tmo(input logic ok);
        if (!ok) begin
            $display("Error %0t: timeout", $time);
            failures++;
            end_of_test;
        end
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, exp, input logic err);
        logic r;
        logic e;
        logic [31:0] rd;
        r = 1'b0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 50 && !r; i++) begin
            #1 {r, e, rd} = {pready, pslverr, prdata};
            @(posedge pclk);
        end
        tmo(r);
        {psel, penable} <= 2'b00;
        if (!wr) chk(rd, exp);
        chk(e, err);
        $display("apb %0d at %h done", wr, a);
    endtask
    task automatic look(input logic [VA_W-1:0] v, input int xlat);
        logic r;
        logic [63:0] key;
        r = 1'b0;
        key = {application_space_tag, v[VA_W-1:PG_W]};
        if (s1 && !seen.exists(key)) exp_walks++;
        if (s1) seen[key] = 1'b1;
        @(posedge pclk);
        {req_valid, req_va, req_fetch, req_level} <= {1'b1, v, v[0], 1'b0, v[1]};
        for (int i = 0; i < 50 && !r; i++) begin
            #1 r = req_ready;
            @(posedge pclk);
        end
        tmo(r);
        req_valid <= 1'b0;
        for (lat = 1; lat < 80; lat++) begin
            @(posedge pclk);
            #1;
            if (resp_valid) break;
        end
        tmo(resp_valid);
        chk(resp_pa, s1 ? {v[39:12] + 28'h1, v[11:0]} : v[39:0]);
        chk({resp_attr, resp_perm}, s1 ? {8'h5A, 2'h1} : {ATTR_BYPASS, PERM_FULL});
        chk(resp_fetch, v[0]);
        chk(walks, exp_walks);
        if (xlat >= 0) chk(lat, xlat);
        $display("lookup %h took %0d", v, lat);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, req_valid, req_fetch, req_va} = '0;
        {req_level, req_secure, walk_fill_big, walk_fill_global, s1, application_space_tag} = '0;
        {failures, cmp_count, exp_walks, seed} = {32'd0, 32'd0, 32'd0, 32'd86379};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, '0, CTRL_RST, 1'b0);
        apb(1'b0, 12'h0F0, '0, '0, 1'b1);
        va = 48'({$random(seed), $random(seed)});
        look(~va, 5);
        apb(1'b1, OFS_CTRL, 32'h1, '0, 1'b0);
        s1 = 1'b1;
        look(va, -1);
        look(va, 1);
        apb(1'b1, OFS_APPLICATION_SPACE_TAG, 32'h7, '0, 1'b0);
        application_space_tag = 16'h7;
        look(va, -1);
        apb(1'b1, OFS_APPLICATION_SPACE_TAG, '0, '0, 1'b0);
        application_space_tag = '0;
        look(va, -1);
        apb(1'b1, OFS_MAINT, 32'h1, '0, 1'b0);
        seen.delete();
        look(va, -1);
        chk(invals, 1);
        repeat (6) begin
            va = 48'({$random(seed), $random(seed)});
            look(va, -1);
            look(va, 1);
        end
        end_of_test;
    end
endmodule // two_stage_tlb_lookup_test
